// File: sim/gate_drive_ocp_config_chk.sv
/*
  Port assertions for the gate-drive configuration block.
  Assumes one clock clk and asynchronous active-high rst.
*/
`timescale 1ns/1ns
module gate_drive_ocp_config_chk import gate_drive_pkg::*; #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  // pins
  input wire logic drain_source_overcurrent,
  input wire logic shunt_overcurrent,
  input wire logic pwm_in,
  input wire logic low_gate_on,
  // outputs
  input wire drive_settings_s settings,
  input wire logic peak_current_active,
  input wire logic gate_disable,
  input wire logic fault_report,
  input wire logic irq
);
  logic [1:0] up_reg;
  logic [1:0] up_next;
  wire oc_any = drain_source_overcurrent | shunt_overcurrent;
  always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up_reg <= 2'h0;
    else up_reg <= up_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence clear_wr;
    wr_en && addr == 4'h2 && wr_data[0];
  endsequence
  sequence fault_gone;
    ##[1:3] !fault_report;
  endsequence
  rd_idle_a:
    assert property (!rd_en |=> rd_data == '0) else $error("read data not idle");
  rd_unmapped_a:
    assert property (rd_en && !(addr inside {4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha}) |=> rd_data == '0)
      else $error("unmapped read not zero");
  disable_report_a:
    assert property (gate_disable |-> fault_report) else $error("gate disabled without fault");
  onset_together_a:
    assert property ($rose(gate_disable) |-> $rose(fault_report)) else $error("gate disable rose alone");
  fault_filter_a:
    assert property ($rose(fault_report) |-> $past(oc_any, 8)) else $error("fault without persistent overcurrent");
  clear_fault_a:
    assert property (clear_wr |-> fault_gone) else $error("fault not cleared");
  peak_min_a:
    assert property ($rose(peak_current_active) |-> peak_current_active [*5]) else $error("peak pulse short");
  decode_time_a:
    assert property (up_reg == 2'h3 |-> settings.peak_hold_cycles inside {8'h05, 8'h0a, 8'h14, 8'h28}
      && settings.dead_time_cycles inside {4'h1, 4'h2, 4'h4}) else $error("timing decode out of set");
  trip_set_a:
    assert property (up_reg == 2'h3 |-> settings.trip_mv inside {11'h03c, 11'h046, 11'h050, 11'h05a, 11'h064,
      11'h0c8, 11'h12c, 11'h190, 11'h1f4, 11'h258, 11'h2bc, 11'h320, 11'h384, 11'h3e8, 11'h5dc, 11'h7d0})
      else $error("trip level out of set");
endmodule
bind gate_drive_ocp_config gate_drive_ocp_config_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) gate_drive_ocp_config_chk_inst (
  .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .drain_source_overcurrent(drain_source_overcurrent), .shunt_overcurrent(shunt_overcurrent), .pwm_in(pwm_in),
  .low_gate_on(low_gate_on), .settings(settings), .peak_current_active(peak_current_active),
  .gate_disable(gate_disable), .fault_report(fault_report), .irq(irq));

// File: sim/gate_drive_ocp_config_test.sv
/*
  Register-level testbench for the gate-drive configuration block.
  Assumes the power-stage model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`include "gate_drive_consts.svh"
module gate_drive_ocp_config_test import gate_drive_pkg::*; ;
  logic clk, rst, wr_en, rd_en, pwm_in, low_gate_on, start, use_shunt, ds_oc, sh_oc, peak, gdis, frep, irq;
  logic [3:0] addr;
  logic [10:0] wr_data, rd_data, q;
  logic [7:0] len;
  drive_settings_s settings;
  int errors, compares, n;
  logic [10:0] src_t [16] = '{11'h032, 11'h032, 11'h064, 11'h096, 11'h12c, 11'h15e, 11'h190, 11'h1c2,
    11'h226, 11'h258, 11'h28a, 11'h2bc, 11'h2ee, 11'h320, 11'h352, 11'h384};
  logic [10:0] snk_t [16] = '{11'h064, 11'h064, 11'h0c8, 11'h12c, 11'h258, 11'h2bc, 11'h320, 11'h384,
    11'h44c, 11'h4b0, 11'h514, 11'h578, 11'h708, 11'h708, 11'h708, 11'h76c};
  logic [10:0] trip_t [16] = '{11'h03c, 11'h046, 11'h050, 11'h05a, 11'h064, 11'h0c8, 11'h12c, 11'h190,
    11'h1f4, 11'h258, 11'h2bc, 11'h320, 11'h384, 11'h3e8, 11'h5dc, 11'h7d0};
  logic [3:0] dead_t [4] = '{4'h1, 4'h1, 4'h2, 4'h4};

  gate_drive_ocp_config #(.RETRY_LONG_CYCLES(40)) gate_drive_ocp_config_inst (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .drain_source_overcurrent(ds_oc), .shunt_overcurrent(sh_oc), .pwm_in(pwm_in), .low_gate_on(low_gate_on),
    .settings(settings), .peak_current_active(peak), .gate_disable(gdis), .fault_report(frep), .irq(irq));
  power_stage_model power_stage_model_inst (
    .clk(clk), .start(start), .len(len), .use_shunt(use_shunt), .ds_oc(ds_oc), .sh_oc(sh_oc));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task give_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [10:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [10:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 q = rd_data;
    chk($sformatf("reg%h", a), e, q);
  endtask
  task settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // overcurrent pulse of l cycles, then wait past filter and state update
  task ocp(input logic [7:0] l, input logic sh);
    @(posedge clk);
    start <= 1'b1;
    len <= l;
    use_shunt <= sh;
    @(posedge clk);
    start <= 1'b0;
    repeat (l + 12) @(posedge clk);
    #1;
  endtask

  initial begin
    #3000000;
    errors++;
    give_verdict();
  end

  initial begin
    {wr_en, rd_en, pwm_in, low_gate_on, start, use_shunt} = 6'h00;
    addr = 4'h0;
    wr_data = 11'h000;
    len = 8'h00;
    errors = 0;
    compares = 0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(`ADDR_LOW_DRIVE, `LOW_DRIVE_RESET);
    rchk(`ADDR_OCP_CTRL, `OCP_CTRL_RESET);
    rchk(`ADDR_LOCK, {`LOCK_RESET, 8'h00});
    rchk(`ADDR_IRQ_MASK, 11'h000);
    rchk(`ADDR_IRQ_STATUS, 11'h000);
    rchk(4'h6, 11'h000);
    for (int i = 0; i < 16; i++) begin
      wr(`ADDR_LOW_DRIVE, {i[0], i[1:0], i[3:0], i[3:0]});
      wr(`ADDR_OCP_CTRL, {1'b0, i[1:0], i[3:2], 2'h0, i[3:0]});
      settle();
      chk("hold", 11'h005 << i[1:0], {3'h0, settings.peak_hold_cycles});
      chk("dead", {7'h0, dead_t[i[1:0]]}, {7'h0, settings.dead_time_cycles});
      chk("src", src_t[i], settings.source_ma);
      chk("snk", snk_t[i], settings.sink_ma);
      chk("trip", trip_t[i], settings.trip_mv);
      chk("cbc", {10'h0, i[0] && i[3:2] == 2'h1}, {10'h0, settings.cbc_active});
      rchk(`ADDR_LOW_DRIVE, {i[0], i[1:0], i[3:0], i[3:0]});
      rchk(`ADDR_OCP_CTRL, {1'b0, i[1:0], i[3:2], 2'h0, i[3:0]});
      if (i < 4) begin
        @(posedge clk);
        low_gate_on <= 1'b1;
        n = 0;
        repeat (60) begin
          @(posedge clk);
          #1 if (peak === 1'b1) n++;
        end
        chk("peak", 11'h005 << i, n[10:0]);
        @(posedge clk);
        low_gate_on <= 1'b0;
      end
    end
    wr(`ADDR_LOCK, {`LOCK_CODE, 8'h00});
    rchk(`ADDR_LOCK, {`LOCK_CODE, 8'h00});
    wr(`ADDR_OCP_CTRL, 11'h000);
    rchk(`ADDR_OCP_CTRL, 11'h3cf);
    wr(`ADDR_LOCK, 11'h100);
    rchk(`ADDR_LOCK, {`LOCK_CODE, 8'h00});
    wr(`ADDR_LOCK, {`UNLOCK_CODE, 8'h00});
    wr(`ADDR_LOW_DRIVE, 11'h3ff);
    rchk(`ADDR_LOW_DRIVE, 11'h3ff);
    wr(`ADDR_IRQ_MASK, 11'h001);
    for (int d = 0; d < 4; d++) begin
      wr(`ADDR_OCP_CTRL, {1'b0, 2'h1, 2'h0, d[1:0], 4'h9});
      ocp((8'h0a << d) - 8'h03, d[0]);
      chk("short", 11'h000, {10'h0, frep});
      ocp((8'h0a << d) + 8'h04, d[0]);
      chk("frep", 11'h001, {10'h0, frep});
      chk("irq", 11'h001, {10'h0, irq});
      repeat (100) @(posedge clk);
      #1 chk("gdis", 11'h001, {10'h0, gdis});
      rchk(`ADDR_IRQ_STATUS, 11'h001);
      wr(`ADDR_FAULT_CLEAR, 11'h001);
      settle();
      chk("clr", 11'h000, {10'h0, frep});
      rchk(`ADDR_FAULT_CLEAR, 11'h000);
      wr(`ADDR_IRQ_STATUS, 11'h001);
      settle();
      chk("irqclr", 11'h000, {10'h0, irq});
    end
    for (int r = 0; r < 2; r++) begin
      wr(`ADDR_OCP_CTRL, {r[0], 2'h1, 2'h1, 2'h0, 4'h9});
      ocp(8'h0e, 1'b0);
      chk("retry", 11'h001, {10'h0, gdis});
      rchk(`ADDR_FAULT_STATE, 11'h007);
      repeat (r ? 400 : 20) @(posedge clk);
      #1 chk("wait", 11'h001, {10'h0, gdis});
      repeat (r ? 200 : 40) @(posedge clk);
      #1 chk("resume", 11'h000, {10'h0, frep});
      rchk(`ADDR_IRQ_STATUS, 11'h003);
      wr(`ADDR_IRQ_STATUS, 11'h003);
    end
    wr(`ADDR_LOW_DRIVE, 11'h7ff);
    wr(`ADDR_OCP_CTRL, {1'b1, 2'h1, 2'h1, 2'h0, 4'h9});
    ocp(8'h0e, 1'b1);
    repeat (600) @(posedge clk);
    #1 chk("cbc", 11'h001, {10'h0, gdis});
    @(posedge clk);
    pwm_in <= 1'b1;
    settle();
    settle();
    chk("pwm", 11'h000, {10'h0, gdis});
    @(posedge clk);
    pwm_in <= 1'b0;
    wr(`ADDR_IRQ_STATUS, 11'h003);
    wr(`ADDR_IRQ_MASK, 11'h000);
    wr(`ADDR_OCP_CTRL, {1'b0, 2'h1, 2'h2, 2'h0, 4'h9});
    ocp(8'h0e, 1'b0);
    chk("rep", 11'h001, {10'h0, frep});
    chk("repg", 11'h000, {10'h0, gdis});
    rchk(`ADDR_FAULT_STATE, 11'h001);
    chk("mask", 11'h000, {10'h0, irq});
    wr(`ADDR_IRQ_MASK, 11'h001);
    settle();
    chk("unmask", 11'h001, {10'h0, irq});
    wr(`ADDR_FAULT_CLEAR, 11'h001);
    wr(`ADDR_IRQ_STATUS, 11'h001);
    wr(`ADDR_OCP_CTRL, {1'b0, 2'h1, 2'h3, 2'h0, 4'h9});
    ocp(8'h0e, 1'b1);
    chk("off", 11'h000, {10'h0, frep});
    chk("offg", 11'h000, {10'h0, gdis});
    rchk(`ADDR_IRQ_STATUS, 11'h000);
    give_verdict();
  end
endmodule

// File: sim/power_stage_model.sv
/*
  Power-stage side model: raises one overcurrent pin for a commanded number of cycles.
  Assumes start is a one-cycle strobe on clk from the bench.
*/
`timescale 1ns/1ns
module power_stage_model (
  // clock and command
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] len,
  input wire logic use_shunt,
  // pins
  output logic ds_oc,
  output logic sh_oc
);
  logic [7:0] left = 8'h00;
  logic sel = 1'b0;
  always @(posedge clk) begin
    if (start) begin
      left <= len;
      sel <= use_shunt;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign ds_oc = (left != 8'h00) && !sel;
  assign sh_oc = (left != 8'h00) && sel;
endmodule

// File: src/gate_drive_consts.svh
/*
  Offsets, field positions, reset values and timing figures for the low-side gate-drive
  and overcurrent-protection configuration block.
  Assumes a 10 MHz device clock and a 4-bit register index on the plain register port.
*/
`ifndef GATE_DRIVE_CONSTS_SVH
`define GATE_DRIVE_CONSTS_SVH

// register indices
`define ADDR_FAULT_CLEAR 4'h2
`define ADDR_LOCK 4'h3
`define ADDR_LOW_DRIVE 4'h4
`define ADDR_OCP_CTRL 4'h5
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_MASK 4'h9
`define ADDR_FAULT_STATE 4'ha

// field positions
`define FAULT_CLEAR_BIT 0
`define LOCK_LSB 8
`define LOCK_MSB 10
`define IRQ_DETECT_BIT 0
`define IRQ_RECOVER_BIT 1

// reset values and lock codes
`define LOW_DRIVE_RESET 11'h7ff
`define OCP_CTRL_RESET 11'h169
`define LOCK_RESET 3'h3
`define LOCK_CODE 3'h6
`define UNLOCK_CODE 3'h3
`define IRQ_MASK_RESET 2'h0

// timing
`define CLK_PERIOD_NS 100
`define PEAK_BASE_NS 500
`define DEAD_BASE_NS 50
`define DEGLITCH_BASE_US 1
`define RETRY_LONG_MS 8
`define RETRY_SHORT_US 50
`define PEAK_BASE_CYC ((`PEAK_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEGLITCH_BASE_CYC ((`DEGLITCH_BASE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RETRY_LONG_CYC ((`RETRY_LONG_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RETRY_SHORT_CYC ((`RETRY_SHORT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: src/gate_drive_ocp_config.sv
/*
  Low-side gate-drive and overcurrent-protection configuration block: registers,
  lock, decoded drive settings, overcurrent filter, fault handling and interrupt.
  Assumes a plain register port on clk and overcurrent, pwm and gate pins from outside.
*/
// Function
// - peak-drive-time code selects 500, 1000, 2000 or 4000 ns of peak current.
// - cycle-by-cycle bit acts only while overcurrent mode is 01.
// - low-side source code maps 50 mA at 0000 to 900 mA at top.
// - low-side sink code maps 100 mA at 0000, 1400 mA at 1011, then 1800+.
// - retry bit selects 8 ms wait when clear, 50 us when set.
// - dead-time code selects 100, 100, 200 or 400 ns gap; 50 ns rounds up to one cycle.
// - mode 00 latches the overcurrent fault until explicitly cleared.
// - mode 01 fault clears itself after retry time, or at next pwm rise if cycle-by-cycle bit set; operation resumes.
// - mode 10 only reports the fault, gate outputs unchanged.
// - mode 11 neither reports nor acts on overcurrent.
// - deglitch code requires 1, 2, 4 or 8 us persistence before fault.
// - trip level code selects 0.06 V at 0000 to 2 V at 1111.
// - writing 110 to lock field blocks config writes; 011 unlocks.
// - writing one to clear bit clears latched faults; bit self-returns to zero.
`timescale 1ns/1ns
`include "gate_drive_consts.svh"
module gate_drive_ocp_config import gate_drive_pkg::*; #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 11,
  parameter int RETRY_W = 17,
  parameter int RETRY_LONG_CYCLES = `RETRY_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // pins from the power stage and controller
  input wire logic drain_source_overcurrent,
  input wire logic shunt_overcurrent,
  input wire logic pwm_in,
  input wire logic low_gate_on,
  // drive settings and status
  output drive_settings_s settings,
  output logic peak_current_active,
  output logic gate_disable,
  output logic fault_report,
  output logic irq
);

  // pin synchronisers: stage one feeds stage two only
  logic [3:0] sync1_reg, sync2_reg, sync_prev_reg;
  logic oc_cond, pwm_rise, gate_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync_prev_reg <= 4'h0;
    end else begin
      sync1_reg <= {low_gate_on, pwm_in, shunt_overcurrent, drain_source_overcurrent};
      sync2_reg <= sync1_reg;
      sync_prev_reg <= sync2_reg;
    end
  end

  assign oc_cond = sync2_reg[0] | sync2_reg[1];
  assign pwm_rise = sync2_reg[2] & ~sync_prev_reg[2];
  assign gate_rise = sync2_reg[3] & ~sync_prev_reg[3];

  // decode tables
  function automatic logic [10:0] source_ma_of(input logic [3:0] code);
    logic [10:0] t [16];
    t = '{11'd50, 11'd50, 11'd100, 11'd150, 11'd300, 11'd350, 11'd400, 11'd450,
          11'd550, 11'd600, 11'd650, 11'd700, 11'd750, 11'd800, 11'd850, 11'd900};
    return t[code];
  endfunction

  function automatic logic [10:0] sink_ma_of(input logic [3:0] code);
    logic [10:0] t [16];
    t = '{11'd100, 11'd100, 11'd200, 11'd300, 11'd600, 11'd700, 11'd800, 11'd900,
          11'd1100, 11'd1200, 11'd1300, 11'd1400, 11'd1800, 11'd1800, 11'd1800, 11'd1900};
    return t[code];
  endfunction

  function automatic logic [10:0] trip_mv_of(input logic [3:0] code);
    logic [10:0] t [16];
    t = '{11'd60, 11'd70, 11'd80, 11'd90, 11'd100, 11'd200, 11'd300, 11'd400,
          11'd500, 11'd600, 11'd700, 11'd800, 11'd900, 11'd1000, 11'd1500, 11'd2000};
    return t[code];
  endfunction

  // base time doubled per code step, rounded up, never below one cycle
  function automatic logic [7:0] doubled_cycles(input int base_ns, input logic [1:0] code);
    int ns;
    int cyc;
    ns = base_ns << code;
    cyc = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return 8'(cyc);
  endfunction

  // configuration registers
  low_drive_s low_drive_reg, low_drive_next;
  ocp_ctrl_s ocp_reg, ocp_next;
  logic [2:0] lock_reg, lock_next;
  logic clear_reg, clear_next;
  logic locked;
  logic wr_lock, wr_low, wr_ocp, wr_clear;

  assign locked = (lock_reg == `LOCK_CODE);
  assign wr_lock = wr_en && (addr == `ADDR_LOCK);
  assign wr_low = wr_en && (addr == `ADDR_LOW_DRIVE);
  assign wr_ocp = wr_en && (addr == `ADDR_OCP_CTRL);
  assign wr_clear = wr_en && (addr == `ADDR_FAULT_CLEAR);

  always_comb begin
    low_drive_next = low_drive_reg;
    ocp_next = ocp_reg;
    lock_next = lock_reg;
    clear_next = wr_clear && wr_data[`FAULT_CLEAR_BIT];
    if (wr_lock) begin
      if (!locked && wr_data[`LOCK_MSB:`LOCK_LSB] == `LOCK_CODE) begin
        lock_next = `LOCK_CODE;
      end else if (locked && wr_data[`LOCK_MSB:`LOCK_LSB] == `UNLOCK_CODE) begin
        lock_next = `UNLOCK_CODE;
      end
    end
    if (wr_low && !locked) begin
      low_drive_next = low_drive_s'(wr_data);
    end
    if (wr_ocp && !locked) begin
      ocp_next = ocp_ctrl_s'(wr_data);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_drive_reg <= low_drive_s'(`LOW_DRIVE_RESET);
      ocp_reg <= ocp_ctrl_s'(`OCP_CTRL_RESET);
      lock_reg <= `LOCK_RESET;
      clear_reg <= 1'b0;
    end else begin
      low_drive_reg <= low_drive_next;
      ocp_reg <= ocp_next;
      lock_reg <= lock_next;
      clear_reg <= clear_next;
    end
  end

  overcurrent_response_select_e mode;
  assign mode = overcurrent_response_select_e'(ocp_reg.overcurrent_response_select);

  // decoded settings
  drive_settings_s settings_reg, settings_next;

  always_comb begin
    settings_next.peak_hold_cycles = doubled_cycles(`PEAK_BASE_NS, low_drive_reg.peak_current_hold_time);
    settings_next.dead_time_cycles = 4'(doubled_cycles(`DEAD_BASE_NS, ocp_reg.dead_time_code));
    settings_next.source_ma = source_ma_of(low_drive_reg.low_source_current_code);
    settings_next.sink_ma = sink_ma_of(low_drive_reg.low_sink_current_code);
    settings_next.trip_mv = trip_mv_of(ocp_reg.drain_source_trip_level);
    settings_next.cbc_active = low_drive_reg.cycle_by_cycle_clear && (mode == MODE_RETRY);
  end

  // peak current timer started by each low-side turn-on
  logic [7:0] peak_cnt_reg, peak_cnt_next;
  logic peak_active_reg, peak_active_next;

  always_comb begin
    peak_cnt_next = peak_cnt_reg;
    if (gate_rise) begin
      peak_cnt_next = settings_reg.peak_hold_cycles;
    end else if (peak_cnt_reg != 8'h00) begin
      peak_cnt_next = peak_cnt_reg - 8'h01;
    end
    peak_active_next = (peak_cnt_next != 8'h00);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settings_reg <= '0;
      peak_cnt_reg <= 8'h00;
      peak_active_reg <= 1'b0;
    end else begin
      settings_reg <= settings_next;
      peak_cnt_reg <= peak_cnt_next;
      peak_active_reg <= peak_active_next;
    end
  end

  // overcurrent persistence filter
  logic detect;
  logic [7:0] deg_threshold;

  assign deg_threshold = 8'(`DEGLITCH_BASE_CYC) << ocp_reg.overcurrent_filter_time;

  ocp_deglitch #(
    .CNT_W(8)
  ) deglitch (
    .clk(clk),
    .rst(rst),
    .enable(mode != MODE_OFF),
    .cond(oc_cond),
    .threshold(deg_threshold),
    .detect(detect)
  );

  // fault state machine
  fault_state_e state_reg, state_next;
  logic [RETRY_W-1:0] retry_reg, retry_next;
  logic recover;
  logic gate_disable_reg, gate_disable_next;
  logic fault_reg, fault_next;

  always_comb begin
    state_next = state_reg;
    retry_next = retry_reg;
    recover = 1'b0;
    unique case (state_reg)
      ST_RUN: begin
        if (detect) begin
          unique case (mode)
            MODE_LATCH: state_next = ST_LATCHED;
            MODE_RETRY: begin
              if (settings_reg.cbc_active) begin
                state_next = ST_CBC;
              end else begin
                state_next = ST_RETRY;
                retry_next = ocp_reg.fault_retry_wait ? RETRY_W'(`RETRY_SHORT_CYC) :
                  RETRY_W'(RETRY_LONG_CYCLES);
              end
            end
            MODE_REPORT: state_next = ST_REPORT;
            MODE_OFF: state_next = ST_RUN;
          endcase
        end
      end
      ST_RETRY: begin
        if (clear_reg) begin
          state_next = ST_RUN;
        end else if (retry_reg <= RETRY_W'(1)) begin
          state_next = ST_RUN;
          recover = 1'b1;
        end else begin
          retry_next = retry_reg - RETRY_W'(1);
        end
      end
      ST_CBC: begin
        if (clear_reg) begin
          state_next = ST_RUN;
        end else if (pwm_rise) begin
          state_next = ST_RUN;
          recover = 1'b1;
        end
      end
      ST_LATCHED, ST_REPORT: begin
        if (clear_reg) begin
          state_next = ST_RUN;
        end
      end
    endcase
    if (state_next != ST_RETRY) begin
      retry_next = '0;
    end
    gate_disable_next = (state_next == ST_LATCHED) || (state_next == ST_RETRY) || (state_next == ST_CBC);
    fault_next = (state_next != ST_RUN);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
      retry_reg <= '0;
      gate_disable_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      retry_reg <= retry_next;
      gate_disable_reg <= gate_disable_next;
      fault_reg <= fault_next;
    end
  end

  // interrupt status, mask and read data
  logic [1:0] irq_status_reg, irq_status_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  logic irq_reg, irq_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;

  always_comb begin
    irq_status_next = irq_status_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_en && addr == `ADDR_IRQ_STATUS) begin
      irq_status_next = irq_status_next & ~wr_data[1:0];
    end
    if (wr_en && addr == `ADDR_IRQ_MASK) begin
      irq_mask_next = wr_data[1:0];
    end
    // events win over a same-cycle clear
    irq_status_next[`IRQ_DETECT_BIT] = irq_status_next[`IRQ_DETECT_BIT] | detect;
    irq_status_next[`IRQ_RECOVER_BIT] = irq_status_next[`IRQ_RECOVER_BIT] | recover;
    irq_next = |(irq_status_next & irq_mask_next);
    rd_data_next = '0;
    if (rd_en) begin
      unique case (addr)
        `ADDR_LOCK: rd_data_next[`LOCK_MSB:`LOCK_LSB] = lock_reg;
        `ADDR_LOW_DRIVE: rd_data_next = DATA_W'(low_drive_reg);
        `ADDR_OCP_CTRL: rd_data_next = DATA_W'(ocp_reg);
        `ADDR_IRQ_STATUS: rd_data_next[1:0] = irq_status_reg;
        `ADDR_IRQ_MASK: rd_data_next[1:0] = irq_mask_reg;
        `ADDR_FAULT_STATE: rd_data_next[2:0] = {state_reg == ST_RETRY, gate_disable_reg, fault_reg};
        default: rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status_reg <= 2'h0;
      irq_mask_reg <= `IRQ_MASK_RESET;
      irq_reg <= 1'b0;
      rd_data_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign settings = settings_reg;
  assign peak_current_active = peak_active_reg;
  assign gate_disable = gate_disable_reg;
  assign fault_report = fault_reg;
  assign irq = irq_reg;

endmodule

// File: src/gate_drive_pkg.sv
/*
  Types shared by the gate-drive configuration block: register layouts, decoded
  settings and the fault state machine.
  Assumes nothing beyond a SystemVerilog tool.
*/
package gate_drive_pkg;

  typedef struct packed {
    logic cycle_by_cycle_clear;
    logic [1:0] peak_current_hold_time;
    logic [3:0] low_source_current_code;
    logic [3:0] low_sink_current_code;
  } low_drive_s;

  typedef struct packed {
    logic fault_retry_wait;
    logic [1:0] dead_time_code;
    logic [1:0] overcurrent_response_select;
    logic [1:0] overcurrent_filter_time;
    logic [3:0] drain_source_trip_level;
  } ocp_ctrl_s;

  typedef struct packed {
    logic [7:0] peak_hold_cycles;
    logic [3:0] dead_time_cycles;
    logic [10:0] source_ma;
    logic [10:0] sink_ma;
    logic [10:0] trip_mv;
    logic cbc_active;
  } drive_settings_s;

  typedef enum logic [1:0] {
    MODE_LATCH,
    MODE_RETRY,
    MODE_REPORT,
    MODE_OFF
  } overcurrent_response_select_e;

  typedef enum {
    ST_RUN,
    ST_LATCHED,
    ST_RETRY,
    ST_CBC,
    ST_REPORT
  } fault_state_e;

endpackage

// File: src/ocp_deglitch.sv
/*
  Persistence filter for the overcurrent condition: gives a one-cycle pulse once the
  condition has stood for threshold consecutive cycles.
  Assumes cond is already synchronised to clk and threshold is at least one.
*/
`timescale 1ns/1ns
module ocp_deglitch #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // condition
  input wire logic enable,
  input wire logic cond,
  input wire logic [CNT_W-1:0] threshold,
  // result
  output logic detect
);

  logic [CNT_W-1:0] count_reg, count_next;
  logic detect_reg, detect_next;

  always_comb begin
    count_next = count_reg;
    detect_next = 1'b0;
    if (!enable || !cond) begin
      count_next = '0;
    end else if (count_reg < threshold) begin
      count_next = count_reg + CNT_W'(1);
      detect_next = (count_reg == threshold - CNT_W'(1));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      detect_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      detect_reg <= detect_next;
    end
  end

  assign detect = detect_reg;

endmodule
